// ==== common/typec_cc_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the CC controller
`ifndef TYPEC_CC_REGS_VH
`define TYPEC_CC_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_ROLE_TERM_CTRL 8'h0a
`define REG_ADVERTISE 8'h06
`define REG_STATUS 8'h08
`define CTRL_RESET 8'h00
`define ADV_RESET 2'h0
`define CTRL_TERM_OFF_BIT 0
`define CTRL_ROLE_HI 5
`define CTRL_ROLE_LO 4
`define ROLE_SEL_FORCE_SRC 2'h2

// ----------------------------------------------------------------
// I2C target
// ----------------------------------------------------------------
// Arbitrary target address
`define I2C_DEV_ADDR 7'h47

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_KHZ 50000
`define TOGGLE_MS 50
`define DEBOUNCE_MS 150
`define TOGGLE_CYCLES (`TOGGLE_MS * `CLK_KHZ)
`define DEBOUNCE_CYCLES (`DEBOUNCE_MS * `CLK_KHZ)
`define STRAP_SETTLE_CYCLES 3'h4

`endif

// ==== sim/typec_cc_properties.sv ====
// Port-level assertions for the CC controller
`timescale 1ns/1ps
module typec_cc_properties (
  input wire clock,
  input wire srst,
  input wire sda_out,
  input wire sda_oe,
  input wire i2c_mode,
  input wire vbus_present,
  input wire vbus_safe0,
  input wire rp_cc1_en,
  input wire rp_cc2_en,
  input wire rd_cc1_en,
  input wire rd_cc2_en,
  input wire vconn_cc1_en,
  input wire vconn_cc2_en,
  input wire attach_indicator_n,
  input wire current_detect_bit_a,
  input wire current_detect_bit_b,
  input wire orientation,
  input wire mux_select
);
  // Recent history covers the input synchronisers
  reg [7:0] s0_hist_reg = 8'h00;
  reg [7:0] vb_hist_reg = 8'h00;
  always @(posedge clock)
  begin
    s0_hist_reg <= {s0_hist_reg[6:0], vbus_safe0};
    vb_hist_reg <= {vb_hist_reg[6:0], vbus_present};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  pullup_pair_a: assert property (rp_cc1_en == rp_cc2_en)
    else $error("pull-ups differ between lines");
  pulldown_pair_a: assert property (rd_cc1_en == rd_cc2_en)
    else $error("pull-downs differ between lines");
  term_exclusive_a: assert property (!(rp_cc1_en && rd_cc1_en))
    else $error("pull-up and pull-down together");
  mux_follow_a: assert property (mux_select == orientation)
    else $error("mux select differs from orientation");
  vconn_cc1_a: assert property (
    vconn_cc1_en |-> rp_cc1_en && !orientation && !vconn_cc2_en)
    else $error("vconn on cc1 wrongly");
  vconn_cc2_a: assert property (vconn_cc2_en |-> rp_cc2_en && orientation)
    else $error("vconn on cc2 wrongly");
  indicator_safe0_a: assert property ($fell(attach_indicator_n) |-> (|s0_hist_reg))
    else $error("indicator low without safe zero");
  indicator_source_a: assert property (!attach_indicator_n |-> rp_cc1_en)
    else $error("indicator low outside source role");
  detect_sink_a: assert property (
    (current_detect_bit_a || current_detect_bit_b) |-> rd_cc1_en && !i2c_mode)
    else $error("current pins outside gpio sink");
  sink_vbus_a: assert property (
    (current_detect_bit_a || current_detect_bit_b) |-> (|vb_hist_reg))
    else $error("sink attached without vbus");
  detach_release_a: assert property (
    $rose(attach_indicator_n) |-> ##[0:2] !vconn_cc1_en && !vconn_cc2_en)
    else $error("vconn kept after detach");
  reset_values_a: assert property (
    disable iff (1'b0) srst |=> attach_indicator_n && orientation && !rp_cc1_en
      && !rd_cc1_en && !vconn_cc1_en && !vconn_cc2_en)
    else $error("wrong values after reset");
  sda_low_only_a: assert property (!sda_out)
    else $error("sda driven high");
endmodule
bind typec_port_role_cc_control typec_cc_properties chk_u (.clock(clock), .srst(srst),
  .sda_out(sda_out), .sda_oe(sda_oe),
  .i2c_mode(i2c_mode), .vbus_present(vbus_present), .vbus_safe0(vbus_safe0),
  .rp_cc1_en(rp_cc1_en), .rp_cc2_en(rp_cc2_en), .rd_cc1_en(rd_cc1_en), .rd_cc2_en(rd_cc2_en),
  .vconn_cc1_en(vconn_cc1_en), .vconn_cc2_en(vconn_cc2_en),
  .attach_indicator_n(attach_indicator_n), .current_detect_bit_a(current_detect_bit_a),
  .current_detect_bit_b(current_detect_bit_b), .orientation(orientation),
  .mux_select(mux_select));

// ==== sim/typec_partner.sv ====
// Port partner on the far end of CC1/CC2: a sink with Rd and Ra, or a source with Rp
`timescale 1ns/1ps
module typec_partner (
  input wire clock,
  input wire [1:0] mode,
  input wire flip,
  input wire ra,
  input wire [1:0] level,
  input wire rp_cc1_en,
  input wire rp_cc2_en,
  input wire rd_cc1_en,
  input wire rd_cc2_en,
  output reg cc1_rd_seen = 1'b0,
  output reg cc2_rd_seen = 1'b0,
  output reg cc1_ra_seen = 1'b0,
  output reg cc2_ra_seen = 1'b0,
  output reg [1:0] cc1_rp_level = 2'h0,
  output reg [1:0] cc2_rp_level = 2'h0
);
  // Mode 1 is a sink, 2 a source; a partner is only seen through our own terminations
  always @(posedge clock)
  begin
    cc1_rd_seen <= rp_cc1_en && mode == 2'h1 && !flip;
    cc2_rd_seen <= rp_cc2_en && mode == 2'h1 && flip;
    cc1_ra_seen <= rp_cc1_en && mode == 2'h1 && ra && flip;
    cc2_ra_seen <= rp_cc2_en && mode == 2'h1 && ra && !flip;
    cc1_rp_level <= (rd_cc1_en && mode == 2'h2 && !flip) ? level : 2'h0;
    cc2_rp_level <= (rd_cc2_en && mode == 2'h2 && flip) ? level : 2'h0;
  end
endmodule

// ==== sim/typec_port_role_cc_control_bench.sv ====
// Self-checking bench: source, sink, dual-role and register-forced source
`timescale 1ns/1ps
`include "typec_cc_regs.vh"
module typec_port_role_cc_control_bench;
  reg clock = 0, srst = 1, scl = 1, sda_host = 1, role_strap_high = 0, role_strap_low = 0;
  reg i2c_mode = 0, vbus_present = 0, vbus_safe0 = 0, p_flip = 0, p_ra = 0;
  reg [1:0] current_strap = 0, p_mode = 0, p_level = 0, lvl;
  reg [31:0] seed;
  wire sda_out, sda_oe, rp_cc1_en, rp_cc2_en, rd_cc1_en, rd_cc2_en, vconn_cc1_en, vconn_cc2_en;
  wire attach_indicator_n, current_detect_bit_a, current_detect_bit_b, orientation, mux_select;
  wire cc1_rd_seen, cc1_ra_seen, cc2_rd_seen, cc2_ra_seen;
  wire [1:0] rp_level, cc1_rp_level, cc2_rp_level;
  // Open-drain SDA with pull-up
  wire sda_in = sda_host & ~sda_oe;
  wire [13:0] obs = {rp_cc1_en, rp_cc2_en, rp_level, rd_cc1_en, rd_cc2_en, vconn_cc1_en,
    vconn_cc2_en, attach_indicator_n, current_detect_bit_a, current_detect_bit_b, orientation,
    mux_select, sda_oe};
  logic [27:0] q[$];
  logic [27:0] ent;
  logic [7:0] rd;
  int num_errors = 0, cmp_count = 0, k;
  typec_port_role_cc_control #(.TOGGLE_CYCLES(20), .DEBOUNCE_CYCLES(10)) dut_u (
    .clock(clock), .srst(srst), .scl(scl), .sda_in(sda_in), .role_strap_high(role_strap_high),
    .role_strap_low(role_strap_low), .i2c_mode(i2c_mode), .current_strap(current_strap),
    .cc1_rd_seen(cc1_rd_seen), .cc1_ra_seen(cc1_ra_seen), .cc2_rd_seen(cc2_rd_seen),
    .cc2_ra_seen(cc2_ra_seen), .cc1_rp_level(cc1_rp_level), .cc2_rp_level(cc2_rp_level),
    .vbus_present(vbus_present), .vbus_safe0(vbus_safe0), .sda_out(sda_out), .sda_oe(sda_oe),
    .rp_cc1_en(rp_cc1_en), .rp_cc2_en(rp_cc2_en), .rp_level(rp_level), .rd_cc1_en(rd_cc1_en),
    .rd_cc2_en(rd_cc2_en), .vconn_cc1_en(vconn_cc1_en), .vconn_cc2_en(vconn_cc2_en),
    .attach_indicator_n(attach_indicator_n), .current_detect_bit_a(current_detect_bit_a),
    .current_detect_bit_b(current_detect_bit_b), .orientation(orientation),
    .mux_select(mux_select));
  typec_partner partner_u (.clock(clock), .mode(p_mode), .flip(p_flip), .ra(p_ra),
    .level(p_level), .rp_cc1_en(rp_cc1_en), .rp_cc2_en(rp_cc2_en), .rd_cc1_en(rd_cc1_en),
    .rd_cc2_en(rd_cc2_en), .cc1_rd_seen(cc1_rd_seen), .cc2_rd_seen(cc2_rd_seen),
    .cc1_ra_seen(cc1_ra_seen), .cc2_ra_seen(cc2_ra_seen), .cc1_rp_level(cc1_rp_level),
    .cc2_rp_level(cc2_rp_level));
  initial
  begin
    forever #10 clock = ~clock;
  end
  function logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task check(input logic [13:0] seen, input logic [13:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t outputs %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits up to n cycles for the result, then leaves the note for the monitor
  task chk_obs(input logic [13:0] m, input logic [13:0] e, input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(negedge clock);
      if ((obs & m) === e)
        break;
    end
    q.push_back({m, e});
    @(posedge clock);
  endtask
  // Straps must be static across reset, so each role needs its own reset
  task do_reset(input logic hi, input logic lo, input logic im);
    role_strap_high <= hi;
    role_strap_low <= lo;
    i2c_mode <= im;
    p_mode <= 2'h0;
    srst <= 1'b1;
    tick(5);
    srst <= 1'b0;
    tick(15);
  endtask
  // Sends bits n-1..0 of f between start and stop; keeps the last byte seen on SDA
  task i2c_xfer(input logic [26:0] f, input int n, output logic [7:0] d);
    int b;
    sda_host <= 1'b0;
    tick(8);
    for (b = n - 1; b >= 0; b--)
    begin
      scl <= 1'b0;
      tick(4);
      sda_host <= f[b];
      tick(4);
      scl <= 1'b1;
      tick(4);
      if (b % 9 != 0)
        d = {d[6:0], sda_in};
      // Last slot of a read is the controller's NACK, so SDA is left free there
      if (b % 9 == 0)
        chk_obs(14'h0001, {13'h0, b > 0 || n == 27}, 1);
      tick(3);
    end
    scl <= 1'b0;
    tick(4);
    sda_host <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_host <= 1'b1;
    tick(8);
  endtask
  task i2c_wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    i2c_xfer({`I2C_DEV_ADDR, 1'b0, 1'b1, p, 1'b1, d, 1'b1}, 27, r);
  endtask
  // Pointer set by a write that the read-only offset ignores
  task i2c_rd(input logic [7:0] p, output logic [7:0] d);
    i2c_wr(p, 8'h00);
    i2c_xfer({9'h0, `I2C_DEV_ADDR, 1'b1, 1'b1, 8'hff, 1'b1}, 18, d);
  endtask
  task results;
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    forever
    begin
      wait (q.size() != 0);
      ent = q.pop_front();
      check(obs & ent[27:14], ent[13:0]);
    end
  end
  initial
  begin
    tick(30000);
    num_errors++;
    results();
  end
  initial
  begin
    seed = 32'hbd5a119d;
    for (k = 0; k < 2; k++)
    begin
      seed = xs(seed);
      lvl = {seed[0], ~seed[0]};
      current_strap <= 2'h0;
      vbus_safe0 <= 1'b0;
      do_reset(1'b1, 1'b0, 1'b0);
      chk_obs(14'h3f00, 14'h3000, 40);
      current_strap <= lvl;
      chk_obs(14'h0c00, {2'h0, lvl, 10'h0}, 20);
      p_flip <= k[0];
      p_ra <= ~k[0];
      p_mode <= 2'h1;
      tick(40);
      chk_obs(14'h0026, k ? 14'h0020 : 14'h0026, 1);
      vbus_safe0 <= 1'b1;
      chk_obs(14'h00e0, k ? 14'h0000 : 14'h0040, 20);
      p_mode <= 2'h0;
      chk_obs(14'h00e0, 14'h0020, 60);
    end
    seed = xs(seed);
    lvl = (seed[1:0] == 2'h0) ? 2'h3 : seed[1:0];
    do_reset(1'b0, 1'b1, 1'b0);
    chk_obs(14'h3300, 14'h0300, 40);
    p_flip <= seed[8];
    p_level <= lvl;
    p_mode <= 2'h2;
    tick(60);
    chk_obs(14'h0018, 14'h0000, 1);
    vbus_present <= 1'b1;
    chk_obs(14'h001e, {9'h0, lvl[0], lvl[1], {2{~p_flip}}, 1'b0}, 30);
    i2c_rd(`REG_STATUS, rd);
    check({6'h0, rd}, {9'h0, 1'b1, 1'b0, ~p_flip, lvl});
    vbus_present <= 1'b0;
    chk_obs(14'h0018, 14'h0000, 30);
    do_reset(1'b0, 1'b0, 1'b1);
    chk_obs(14'h3300, 14'h3000, 60);
    chk_obs(14'h3300, 14'h0300, 60);
    i2c_wr(`REG_ROLE_TERM_CTRL, 8'h01);
    chk_obs(14'h3300, 14'h0000, 30);
    i2c_wr(`REG_ROLE_TERM_CTRL, 8'h21);
    i2c_wr(`REG_ROLE_TERM_CTRL, 8'h20);
    for (k = 0; k < 3; k++)
    begin
      tick(25);
      chk_obs(14'h3300, 14'h3000, 1);
    end
    i2c_wr(`REG_ADVERTISE, 8'h02);
    chk_obs(14'h0c00, 14'h0800, 30);
    results();
  end
endmodule

// ==== src/typec_port_role_cc_control.v ====
// Type-C configuration-channel control: role strap, attach, current, VCONN, orientation, I2C
`timescale 1ns/1ps
`include "typec_cc_regs.vh"

// How it works
// RULE_01 - Three-level strap: high means source, low means sink, floating means dual-role.
// RULE_02 - Strap is captured once after reset and held until the next reset.
// RULE_03 - With a floating strap, role-select field 2'b10 forces source-only operation.
// RULE_04 - Source-only role presents pull-ups on both CC lines continuously.
// RULE_05 - Source advertises default current, retuned to the strap or register level.
// RULE_06 - In attached-source state the attach indicator is driven low.
// RULE_07 - VCONN goes to the unused CC line only when an active cable sits there.
// RULE_08 - Host forces source by: termination off, role field 2'b10, termination on.
// RULE_09 - Attach indicator stays high until VBUS reaches safe-zero, then goes low.
// RULE_10 - Sink-only role presents pull-downs on both lines and watches attach and current.
// RULE_11 - Sink debounces CC, then waits for VBUS before declaring attach.
// RULE_12 - Attached sink reports current on two pins (GPIO) or a register field (I2C).
// RULE_13 - Orientation from CC lines steers the two-channel 2:1 SuperSpeed mux.
// RULE_14 - Orientation is also driven on its own general-purpose output.
// RULE_15 - No Power Delivery messaging on CC; e-marking and alternate modes unsupported.
// RULE_16 - Dual-role alternates pull-ups on both lines with pull-downs on both lines.
// RULE_17 - Orientation output is high for CC1 and low for CC2.
// RULE_18 - Detach returns to the unattached state, releases indicator, removes VCONN.
module typec_port_role_cc_control #(
  parameter TOGGLE_CYCLES = `TOGGLE_CYCLES,
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire clock,
  input wire srst,
  input wire scl,
  input wire sda_in,
  input wire role_strap_high,
  input wire role_strap_low,
  input wire i2c_mode,
  input wire [1:0] current_strap,
  input wire cc1_rd_seen,
  input wire cc1_ra_seen,
  input wire cc2_rd_seen,
  input wire cc2_ra_seen,
  input wire [1:0] cc1_rp_level,
  input wire [1:0] cc2_rp_level,
  input wire vbus_present,
  input wire vbus_safe0,
  output reg sda_out,
  output reg sda_oe,
  output reg rp_cc1_en,
  output reg rp_cc2_en,
  output reg [1:0] rp_level,
  output reg rd_cc1_en,
  output reg rd_cc2_en,
  output reg vconn_cc1_en,
  output reg vconn_cc2_en,
  output reg attach_indicator_n,
  output reg current_detect_bit_a,
  output reg current_detect_bit_b,
  output reg orientation,
  output reg mux_select
);

  localparam SYNC_W = 17;
  localparam [SYNC_W-1:0] SYNC_RST = {2'h3, 15'h0000};
  localparam [1:0] SOURCE_ROLE = 2'h0;
  localparam [1:0] SINK_ROLE = 2'h1;
  localparam [1:0] DUAL_ROLE = 2'h2;
  localparam [2:0] ST_UNATT_SRC = 3'h0;
  localparam [2:0] ST_DEB_SRC = 3'h1;
  localparam [2:0] ST_ATT_SRC = 3'h2;
  localparam [2:0] ST_UNATT_SNK = 3'h3;
  localparam [2:0] ST_DEB_SNK = 3'h4;
  localparam [2:0] ST_ATT_SNK = 3'h5;
  localparam [2:0] PH_IDLE = 3'h0;
  localparam [2:0] PH_ADDR = 3'h1;
  localparam [2:0] PH_PTR = 3'h2;
  localparam [2:0] PH_WR = 3'h3;
  localparam [2:0] PH_RD = 3'h4;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [SYNC_W-1:0] pins_raw;
  reg [SYNC_W-1:0] sync1_reg;
  reg [SYNC_W-1:0] sync2_reg;
  reg [SYNC_W-1:0] sync3_reg;
  reg [SYNC_W-1:0] pin_reg;
  integer i;

  assign pins_raw = {scl, sda_in, role_strap_high, role_strap_low, i2c_mode, current_strap,
                     cc1_rd_seen, cc1_ra_seen, cc2_rd_seen, cc2_ra_seen, cc1_rp_level,
                     cc2_rp_level, vbus_present, vbus_safe0};

  always @(posedge clock)
  begin
    if (srst)
    begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      sync3_reg <= SYNC_RST;
      pin_reg <= SYNC_RST;
    end
    else
    begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (i = 0; i < SYNC_W; i = i + 1)
        if (sync2_reg[i] == sync3_reg[i])
          pin_reg[i] <= sync3_reg[i];
    end
  end

  wire scl_s = pin_reg[16];
  wire sda_s = pin_reg[15];
  wire strap_hi_s = pin_reg[14];
  wire strap_lo_s = pin_reg[13];
  wire i2c_mode_s = pin_reg[12];
  wire [1:0] cur_strap_s = pin_reg[11:10];
  wire cc1_rd_s = pin_reg[9];
  wire cc1_ra_s = pin_reg[8];
  wire cc2_rd_s = pin_reg[7];
  wire cc2_ra_s = pin_reg[6];
  wire [1:0] cc1_lvl_s = pin_reg[5:4];
  wire [1:0] cc2_lvl_s = pin_reg[3:2];
  wire vbus_s = pin_reg[1];
  wire safe0_s = pin_reg[0];

  // ----------------------------------------------------------------
  // Role strap capture
  // ----------------------------------------------------------------
  // Sampled only once the synchronisers have filled after reset
  reg [2:0] settle_reg;
  reg [1:0] strap_role_reg;
  reg strap_done_reg;

  always @(posedge clock)
  begin
    if (srst)
    begin
      settle_reg <= 3'h0;
      strap_role_reg <= DUAL_ROLE;
      strap_done_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      settle_reg <= settle_reg + 3'h1;
      if (settle_reg == `STRAP_SETTLE_CYCLES)
      begin
        strap_done_reg <= 1'b1; // RULE_02
        strap_role_reg <= strap_hi_s ? SOURCE_ROLE : (strap_lo_s ? SINK_ROLE : DUAL_ROLE); // RULE_01
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_reg;
  reg [1:0] adv_reg;
  reg [2:0] state_reg;
  reg orient_reg;
  reg [1:0] det_cur_reg;
  wire term_off = ctrl_reg[`CTRL_TERM_OFF_BIT];
  wire force_src = (ctrl_reg[`CTRL_ROLE_HI:`CTRL_ROLE_LO] == `ROLE_SEL_FORCE_SRC);
  wire [1:0] role = (strap_role_reg == DUAL_ROLE && force_src) ? SOURCE_ROLE
                    : strap_role_reg; // RULE_03 RULE_08
  wire att_src = (state_reg == ST_ATT_SRC);
  wire att_snk = (state_reg == ST_ATT_SNK);
  wire [7:0] status_word = {3'h0, att_snk, att_src, orient_reg, det_cur_reg};

  function [7:0] read_mux;
    input [7:0] addr;
    begin
      case (addr)
        `REG_ROLE_TERM_CTRL: read_mux = ctrl_reg;
        `REG_ADVERTISE: read_mux = {6'h00, adv_reg};
        `REG_STATUS: read_mux = status_word;
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // I2C target
  // ----------------------------------------------------------------
  reg scl_d_reg;
  reg sda_d_reg;
  reg [2:0] phase_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  wire [7:0] rd_byte = read_mux(ptr_reg);
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_seen = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  always @(posedge clock)
  begin
    if (srst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      phase_reg <= PH_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      ctrl_reg <= `CTRL_RESET;
      adv_reg <= `ADV_RESET;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      if (start_seen)
      begin
        phase_reg <= PH_ADDR;
        bit_reg <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_seen)
      begin
        phase_reg <= PH_IDLE;
        sda_oe <= 1'b0;
      end
      else if (phase_reg != PH_IDLE && scl_rise)
      begin
        if (bit_reg < 4'h8)
        begin
          shift_reg <= {shift_reg[6:0], (phase_reg == PH_RD) ? 1'b0 : sda_s};
          bit_reg <= bit_reg + 4'h1;
        end
        else
        begin
          // Controller NACK ends a read
          if (phase_reg == PH_RD && sda_s)
            phase_reg <= PH_IDLE;
          bit_reg <= 4'h9;
        end
      end
      else if (phase_reg != PH_IDLE && scl_fall)
      begin
        if (bit_reg == 4'h8)
        begin
          sda_oe <= (phase_reg != PH_RD);
          case (phase_reg)
            PH_ADDR:
            begin
              if (shift_reg[7:1] != `I2C_DEV_ADDR)
              begin
                phase_reg <= PH_IDLE;
                sda_oe <= 1'b0;
              end
              else
                phase_reg <= shift_reg[0] ? PH_RD : PH_PTR;
            end
            PH_PTR:
            begin
              ptr_reg <= shift_reg;
              phase_reg <= PH_WR;
            end
            PH_WR:
            begin
              if (ptr_reg == `REG_ROLE_TERM_CTRL)
                ctrl_reg <= shift_reg; // RULE_08
              if (ptr_reg == `REG_ADVERTISE)
                adv_reg <= shift_reg[1:0];
            end
            default: ;
          endcase
        end
        else if (bit_reg == 4'h9)
        begin
          bit_reg <= 4'h0;
          sda_oe <= 1'b0;
          if (phase_reg == PH_RD)
          begin
            shift_reg <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end
        end
        else if (phase_reg == PH_RD && bit_reg != 4'h0)
          sda_oe <= ~shift_reg[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // Attach state machine
  // ----------------------------------------------------------------
  // No PD message engine exists; CC is only terminated and sensed. RULE_15
  reg [23:0] cnt_reg;
  reg safe0_seen_reg;
  wire sink_seen = cc1_rd_s ^ cc2_rd_s;
  wire src_seen = (cc1_lvl_s != 2'h0) ^ (cc2_lvl_s != 2'h0);
  wire [2:0] unatt_state = (role == SINK_ROLE) ? ST_UNATT_SNK : ST_UNATT_SRC;
  wire toggle_due = (role == DUAL_ROLE) && (cnt_reg == TOGGLE_CYCLES - 1);

  always @(posedge clock)
  begin
    if (srst)
    begin
      state_reg <= ST_UNATT_SRC;
      cnt_reg <= 24'h000000;
      orient_reg <= 1'b1;
      det_cur_reg <= 2'h0;
      safe0_seen_reg <= 1'b0;
    end
    else if (!strap_done_reg || term_off)
    begin
      state_reg <= unatt_state;
      cnt_reg <= 24'h000000;
      safe0_seen_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 24'h000001;
      case (state_reg)
        ST_UNATT_SRC:
        begin
          if (role == SINK_ROLE || toggle_due)
          begin
            state_reg <= ST_UNATT_SNK; // RULE_16
            cnt_reg <= 24'h000000;
          end
          else if (sink_seen)
          begin
            state_reg <= ST_DEB_SRC;
            cnt_reg <= 24'h000000;
          end
        end
        ST_DEB_SRC:
        begin
          if (!sink_seen)
            state_reg <= unatt_state;
          else if (cnt_reg == DEBOUNCE_CYCLES - 1)
          begin
            state_reg <= ST_ATT_SRC;
            orient_reg <= cc1_rd_s; // RULE_13
          end
        end
        ST_ATT_SRC:
        begin
          if (safe0_s)
            safe0_seen_reg <= 1'b1; // RULE_09
          if (!(orient_reg ? cc1_rd_s : cc2_rd_s))
          begin
            state_reg <= unatt_state; // RULE_18
            safe0_seen_reg <= 1'b0;
            cnt_reg <= 24'h000000;
          end
        end
        ST_UNATT_SNK:
        begin
          if (role == SOURCE_ROLE || toggle_due)
          begin
            state_reg <= ST_UNATT_SRC; // RULE_16
            cnt_reg <= 24'h000000;
          end
          else if (src_seen)
          begin
            state_reg <= ST_DEB_SNK;
            cnt_reg <= 24'h000000;
          end
        end
        ST_DEB_SNK:
        begin
          if (!src_seen)
            state_reg <= unatt_state;
          else if (cnt_reg >= DEBOUNCE_CYCLES - 1)
          begin
            cnt_reg <= cnt_reg;
            // Debounce done; attach still needs VBUS
            if (vbus_s)
            begin
              state_reg <= ST_ATT_SNK; // RULE_11
              orient_reg <= (cc1_lvl_s != 2'h0); // RULE_13
            end
          end
        end
        ST_ATT_SNK:
        begin
          det_cur_reg <= orient_reg ? cc1_lvl_s : cc2_lvl_s; // RULE_12
          if (!vbus_s)
          begin
            state_reg <= unatt_state; // RULE_18
            cnt_reg <= 24'h000000;
          end
        end
        default:
          state_reg <= unatt_state;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  wire src_face = (state_reg == ST_UNATT_SRC) || (state_reg == ST_DEB_SRC) || att_src;
  // Termination-off drops VCONN and indicator in step with the pull-ups
  wire att_src_live = att_src && !term_off;

  always @(posedge clock)
  begin
    if (srst)
    begin
      rp_cc1_en <= 1'b0;
      rp_cc2_en <= 1'b0;
      rp_level <= 2'h0;
      rd_cc1_en <= 1'b0;
      rd_cc2_en <= 1'b0;
      vconn_cc1_en <= 1'b0;
      vconn_cc2_en <= 1'b0;
      attach_indicator_n <= 1'b1;
      current_detect_bit_a <= 1'b0;
      current_detect_bit_b <= 1'b0;
      orientation <= 1'b1;
      mux_select <= 1'b1;
    end
    else
    begin
      rp_cc1_en <= strap_done_reg && !term_off && src_face; // RULE_04
      rp_cc2_en <= strap_done_reg && !term_off && src_face; // RULE_04
      rd_cc1_en <= strap_done_reg && !term_off && !src_face; // RULE_10
      rd_cc2_en <= strap_done_reg && !term_off && !src_face; // RULE_10
      rp_level <= i2c_mode_s ? adv_reg : cur_strap_s; // RULE_05
      vconn_cc1_en <= att_src_live && !orient_reg && cc1_ra_s; // RULE_07
      vconn_cc2_en <= att_src_live && orient_reg && cc2_ra_s; // RULE_07
      attach_indicator_n <= !(att_src_live && (safe0_seen_reg || safe0_s)); // RULE_06 RULE_09
      current_detect_bit_a <= att_snk && !i2c_mode_s && det_cur_reg[0]; // RULE_12
      current_detect_bit_b <= att_snk && !i2c_mode_s && det_cur_reg[1]; // RULE_12
      orientation <= orient_reg; // RULE_14 RULE_17
      mux_select <= orient_reg; // RULE_13
    end
  end

endmodule
